// [hdl/tdcs_params.svh]
// Named offsets, field positions, reset values and counts of the test, debug and clock select registers.
// Assumes inclusion by bare name from every design file that decodes these registers.
`ifndef TDCS_PARAMS_SVH
`define TDCS_PARAMS_SVH

`define TDCS_IDX_PORT     16'h03DE
`define TDCS_DATA_PORT    16'h03DF

`define TDCS_IDX_TEST1    8'h03
`define TDCS_IDX_TEST2    8'h04
`define TDCS_IDX_CLKSEL   8'h06
`define TDCS_IDX_STRAP    8'h07

`define TDCS_RST_TEST1    8'h00
`define TDCS_RST_TEST2    8'h00
`define TDCS_RST_CLKSEL   8'h00
`define TDCS_RST_BYTE     8'h00

`define TDCS_T1_SEL       2:0
`define TDCS_T1_FLUSH     4
`define TDCS_T1_SCAN_ATTR 5
`define TDCS_T1_VSYNC     5
`define TDCS_T1_DEBUG     6
`define TDCS_T1_GLOBAL    7
`define TDCS_T2_FORCE_RDY 0

`define TDCS_MODE_CNT     3'h0
`define TDCS_DBG_RSVD     3'h7

`define TDCS_CS_PINS      3:0
`define TDCS_CS_MISC      1:0
`define TDCS_CS_EXTD      2
`define TDCS_MISC_CS      3:2
`define TDCS_EXTD_CS      5

`define TDCS_STRAP_ROMW   0
`define TDCS_STRAP_SETTLE 3'h4

`endif

// [hdl/tdcs_pkg.sv]
// Types shared by the test, debug and clock select register bank.
// Assumes no other package; constants live in tdcs_params.svh.
package tdcs_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tdcs_io_req_s;

  typedef struct packed {
    logic [10:0] vcnt;
    logic [4:0]  row_scan;
    logic [22:0] disp_addr;
    logic [15:0] hcnt;
  } tdcs_crt_cnt_s;

  typedef struct packed {
    logic [2:0] addr_src;
    logic [2:0] state;
    logic       frame;
    logic       cmd;
  } tdcs_dbg_grp_s;

  typedef tdcs_dbg_grp_s [6:0] tdcs_dbg_set_t;

endpackage

// [hdl/tdcs_sync.sv]
// Three-stage synchroniser for pin inputs with agreement filter.
// Assumes the inputs are asynchronous to sys_clk_i; the output moves once stages two and three agree.
`timescale 1ns/1ps
module tdcs_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge sys_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          s1_reg    <= 1'b0;
          s2_reg    <= 1'b0;
          s3_reg    <= 1'b0;
          sync_o[b] <= 1'b0;
        end
        else
        begin
          s1_reg <= async_i[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
          begin
            sync_o[b] <= s3_reg;
          end
        end
      end
    end
  endgenerate
endmodule // tdcs_sync

// [hdl/tdcs_test_mux.sv]
// Selects the counter slice for counter test and the signal group for debug routing.
// Assumes counters and debug groups are on sys_clk_i; the result is combinational and registered by the caller.
`timescale 1ns/1ps
`include "tdcs_params.svh"
module tdcs_test_mux (
  input  wire logic [2:0]             slice_sel_i,
  input  wire logic [2:0]             dbg_sel_i,
  input  wire tdcs_pkg::tdcs_crt_cnt_s crt_cnt_i,
  input  wire tdcs_pkg::tdcs_dbg_set_t dbg_set_i,
  output logic      [15:0]            slice_o,
  output logic      [7:0]             dbg_byte_o
);
  import tdcs_pkg::*;

  always_comb
  begin
    case (slice_sel_i)
      3'h0, 3'h2: slice_o = {5'h00, crt_cnt_i.vcnt};
      3'h1:       slice_o = {8'h00, crt_cnt_i.vcnt[10:8], crt_cnt_i.row_scan};
      3'h3:       slice_o = {8'h00, crt_cnt_i.disp_addr[7:0]};
      3'h4:       slice_o = {8'h00, crt_cnt_i.disp_addr[15:8]};
      3'h5:       slice_o = {9'h000, crt_cnt_i.disp_addr[22:16]};
      3'h6:       slice_o = {8'h00, crt_cnt_i.hcnt[7:0]};
      default:    slice_o = {8'h00, crt_cnt_i.hcnt[15:8]};
    endcase
  end

  // Group layout places address source, state, frame and command from high to low.
  always_comb
  begin
    if (dbg_sel_i == `TDCS_DBG_RSVD)
    begin
      dbg_byte_o = 8'h00;
    end
    else
    begin
      dbg_byte_o = dbg_set_i[dbg_sel_i];
    end
  end
endmodule // tdcs_test_mux

// [hdl/tdcs_regs.sv]
// Test, debug, video clock select and strap registers behind the extended index/data port pair.
// Assumes host I/O requests are one-cycle strobes on sys_clk_i; strap and system data pins are asynchronous.
`timescale 1ns/1ps
`include "tdcs_params.svh"
module tdcs_regs (
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire tdcs_pkg::tdcs_io_req_s  io_req_i,
  output logic      [7:0]              io_rdata_o,
  output logic                         io_rdata_valid_o,
  input  wire logic                    misc_out_wr_i,
  input  wire logic [7:0]              misc_out_wdata_i,
  input  wire logic                    ext_d_wr_i,
  input  wire logic [7:0]              ext_d_wdata_i,
  output logic      [3:0]              clk_sel_pins_o,
  input  wire logic [7:0]              mem_data_strap_lines_i,
  output logic                         rom_wide_o,
  input  wire logic [15:0]             system_data_bus_i,
  output logic      [15:0]             system_data_bus_o,
  output logic                         system_data_bus_oe_o,
  input  wire tdcs_pkg::tdcs_crt_cnt_s crt_cnt_i,
  input  wire logic                    text_mode_i,
  input  wire logic [7:0]              font_data_i,
  input  wire logic [7:0]              attr_data_i,
  input  wire logic [7:0]              graphics_pixel_data_i,
  output logic      [7:0]              font_data_o,
  output logic      [7:0]              attr_data_o,
  output logic      [7:0]              graphics_pixel_data_o,
  input  wire logic                    mem_wr_done_i,
  output logic                         cache_flush_o,
  input  wire logic                    vsync_i,
  output logic                         vsync_o,
  input  wire tdcs_pkg::tdcs_dbg_set_t dbg_set_i,
  input  wire logic [7:0]              pixel_hi_i,
  output logic      [7:0]              pixel_hi_o,
  output logic                         coproc_force_ready_o
);
  import tdcs_pkg::*;

  logic [7:0]  index_reg;
  logic [7:0]  chip_test_debug_control_reg;
  logic [7:0]  coproc_test_control_reg;
  logic [7:0]  video_clock_selection_reg;
  logic [7:0]  board_strap_config_one_reg;
  logic [2:0]  strap_cnt_reg;
  logic        strap_done_reg;
  logic [2:0]  slice_cnt_reg;
  logic        vsync_tog_reg;
  logic        vsync_bit_reg;
  logic [7:0]  strap_sync;
  logic [15:0] sd_sync;
  logic [15:0] slice;
  logic [7:0]  dbg_byte;
  logic [7:0]  rdata_next;
  logic        rhit_next;
  logic        idx_hit;
  logic        dat_hit;
  logic        wr_idx;
  logic        wr_dat;
  logic        rd_idx;
  logic        rd_dat;
  logic        test_on;
  logic        cnt_mode;
  logic        scan_attr;
  logic        dbg_mode;

  assign idx_hit   = io_req_i.addr == `TDCS_IDX_PORT;
  assign dat_hit   = io_req_i.addr == `TDCS_DATA_PORT;
  assign wr_idx    = io_req_i.wr & idx_hit;
  assign wr_dat    = io_req_i.wr & dat_hit;
  assign rd_idx    = io_req_i.rd & idx_hit;
  assign rd_dat    = io_req_i.rd & dat_hit;
  assign test_on   = chip_test_debug_control_reg[`TDCS_T1_GLOBAL];
  assign cnt_mode  = test_on && (chip_test_debug_control_reg[`TDCS_T1_SEL] == `TDCS_MODE_CNT);
  assign scan_attr = test_on && chip_test_debug_control_reg[`TDCS_T1_SCAN_ATTR];
  assign dbg_mode  = chip_test_debug_control_reg[`TDCS_T1_DEBUG];

  tdcs_sync #(.WIDTH(8)) u_strap_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (mem_data_strap_lines_i),
    .sync_o    (strap_sync)
  );

  tdcs_sync #(.WIDTH(16)) u_sd_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (system_data_bus_i),
    .sync_o    (sd_sync)
  );

  tdcs_test_mux u_test_mux (
    .slice_sel_i (slice_cnt_reg),
    .dbg_sel_i   (chip_test_debug_control_reg[`TDCS_T1_SEL]),
    .crt_cnt_i   (crt_cnt_i),
    .dbg_set_i   (dbg_set_i),
    .slice_o     (slice),
    .dbg_byte_o  (dbg_byte)
  );

  // Index first, then data port accesses the indexed register.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      index_reg <= `TDCS_RST_BYTE;
    end
    else if (wr_idx)
    begin
      index_reg <= io_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chip_test_debug_control_reg <= `TDCS_RST_TEST1;
      coproc_test_control_reg     <= `TDCS_RST_TEST2;
    end
    else if (wr_dat)
    begin
      if (index_reg == `TDCS_IDX_TEST1)
      begin
        chip_test_debug_control_reg <= io_req_i.wdata;
      end
      if (index_reg == `TDCS_IDX_TEST2)
      begin
        coproc_test_control_reg <= io_req_i.wdata;
      end
    end
  end

  // One storage serves all three write paths, so every location reads the same bits.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      video_clock_selection_reg <= `TDCS_RST_CLKSEL;
    end
    else if (wr_dat && (index_reg == `TDCS_IDX_CLKSEL))
    begin
      video_clock_selection_reg <= io_req_i.wdata;
    end
    else
    begin
      if (misc_out_wr_i)
      begin
        video_clock_selection_reg[`TDCS_CS_MISC] <= misc_out_wdata_i[`TDCS_MISC_CS];
      end
      if (ext_d_wr_i)
      begin
        video_clock_selection_reg[`TDCS_CS_EXTD] <= ext_d_wdata_i[`TDCS_EXTD_CS];
      end
    end
  end

  assign clk_sel_pins_o = video_clock_selection_reg[`TDCS_CS_PINS];

  // Straps cannot be taken under reset; capture waits until the three-flop filter has passed them on.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      strap_cnt_reg              <= 3'h0;
      strap_done_reg             <= 1'b0;
      board_strap_config_one_reg <= `TDCS_RST_BYTE;
    end
    else if (!strap_done_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == `TDCS_STRAP_SETTLE)
      begin
        board_strap_config_one_reg <= strap_sync;
        strap_done_reg             <= 1'b1;
      end
    end
  end

  assign rom_wide_o = board_strap_config_one_reg[`TDCS_STRAP_ROMW];

  always_comb
  begin
    rdata_next = 8'h00;
    rhit_next  = 1'b1;
    if (rd_idx)
    begin
      rdata_next = index_reg;
    end
    else
    begin
      case (index_reg)
        `TDCS_IDX_TEST1:  rdata_next = chip_test_debug_control_reg;
        `TDCS_IDX_TEST2:  rdata_next = coproc_test_control_reg;
        `TDCS_IDX_CLKSEL: rdata_next = video_clock_selection_reg;
        `TDCS_IDX_STRAP:  rdata_next = board_strap_config_one_reg;
        default:          rhit_next  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      io_rdata_o       <= 8'h00;
      io_rdata_valid_o <= 1'b0;
    end
    else
    begin
      io_rdata_o       <= (rd_idx || (rd_dat && rhit_next)) ? rdata_next : 8'h00;
      io_rdata_valid_o <= rd_idx || (rd_dat && rhit_next);
    end
  end

  // The slice counter free-runs while counter test is active.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      slice_cnt_reg        <= 3'h0;
      system_data_bus_o    <= 16'h0000;
      system_data_bus_oe_o <= 1'b0;
    end
    else
    begin
      slice_cnt_reg        <= cnt_mode ? slice_cnt_reg + 3'h1 : 3'h0;
      system_data_bus_o    <= cnt_mode ? slice : 16'h0000;
      system_data_bus_oe_o <= cnt_mode;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      font_data_o           <= 8'h00;
      attr_data_o           <= 8'h00;
      graphics_pixel_data_o <= 8'h00;
    end
    else
    begin
      font_data_o           <= (scan_attr && text_mode_i) ? sd_sync[15:8] : font_data_i;
      attr_data_o           <= (scan_attr && text_mode_i) ? sd_sync[7:0] : attr_data_i;
      graphics_pixel_data_o <= (scan_attr && !text_mode_i) ? sd_sync[15:8] : graphics_pixel_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cache_flush_o <= 1'b0;
    end
    else
    begin
      cache_flush_o <= mem_wr_done_i && chip_test_debug_control_reg[`TDCS_T1_FLUSH];
    end
  end

  // Either direction of change flips the sync, so software toggles it by writing alternate values.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vsync_bit_reg <= 1'b0;
      vsync_tog_reg <= 1'b0;
    end
    else
    begin
      vsync_bit_reg <= chip_test_debug_control_reg[`TDCS_T1_VSYNC];
      if (vsync_bit_reg != chip_test_debug_control_reg[`TDCS_T1_VSYNC])
      begin
        vsync_tog_reg <= ~vsync_tog_reg;
      end
    end
  end

  assign vsync_o = vsync_i ^ vsync_tog_reg;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pixel_hi_o <= 8'h00;
    end
    else
    begin
      pixel_hi_o <= dbg_mode ? dbg_byte : pixel_hi_i;
    end
  end

  assign coproc_force_ready_o = coproc_test_control_reg[`TDCS_T2_FORCE_RDY];

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_idx_wr(logic [7:0] idx);
    wr_idx && (io_req_i.wdata == idx) ##1 !wr_idx;
  endsequence

  sequence s_dat_wr;
    wr_dat && !misc_out_wr_i && !ext_d_wr_i;
  endsequence

  chk_global_gate: assert property (!test_on |=> !system_data_bus_oe_o)
    else $error("data bus driven without global test enable");
  chk_slice_advance: assert property (cnt_mode && $past(cnt_mode) |-> slice_cnt_reg == $past(slice_cnt_reg) + 3'h1)
    else $error("slice counter did not advance");
  chk_slice_horiz: assert property (cnt_mode && slice_cnt_reg == 3'h6 |=> system_data_bus_o == {8'h00, $past(crt_cnt_i.hcnt[7:0])})
    else $error("horizontal low slice wrong");
  chk_scan_font: assert property (scan_attr && text_mode_i |=> font_data_o == $past(sd_sync[15:8]))
    else $error("font data not replaced in scan test");
  chk_flush_pulse: assert property (mem_wr_done_i |=> cache_flush_o == $past(chip_test_debug_control_reg[`TDCS_T1_FLUSH]))
    else $error("flush does not follow flush bit");
  chk_vsync_flip: assert property ($changed(chip_test_debug_control_reg[`TDCS_T1_VSYNC]) |=> vsync_tog_reg != $past(vsync_tog_reg))
    else $error("vsync did not toggle");
  chk_dbg_reserved: assert property (dbg_mode && chip_test_debug_control_reg[`TDCS_T1_SEL] == `TDCS_DBG_RSVD |=> pixel_hi_o == 8'h00)
    else $error("reserved debug code not zero");
  chk_dbg_route: assert property (dbg_mode && chip_test_debug_control_reg[`TDCS_T1_SEL] == 3'h1 |=> pixel_hi_o == $past(dbg_set_i[1]))
    else $error("debug group not routed");
  chk_force_ready: assert property (s_idx_wr(`TDCS_IDX_TEST2) ##1 (s_dat_wr and io_req_i.wdata[0]) |=> coproc_force_ready_o)
    else $error("force ready not set by write");
  chk_clksel_pins: assert property (s_idx_wr(`TDCS_IDX_CLKSEL) ##1 s_dat_wr |=> clk_sel_pins_o == $past(io_req_i.wdata[3:0]) ##0 video_clock_selection_reg[7:4] == $past(io_req_i.wdata[7:4]))
    else $error("clock select write not on pins");
  chk_misc_image: assert property (misc_out_wr_i && !wr_dat |=> clk_sel_pins_o[1:0] == $past(misc_out_wdata_i[3:2]))
    else $error("misc image not shared");
  chk_strap_ro: assert property (strap_done_reg |=> $stable(board_strap_config_one_reg))
    else $error("strap register changed after load");
  chk_unmapped_zero: assert property (rd_dat && !rhit_next |=> io_rdata_o == 8'h00 && !io_rdata_valid_o)
    else $error("unmapped read not zero");

endmodule // tdcs_regs

// [bench/tdcs_host_model.sv]
// Host processor model issuing byte cycles on the extended index and data ports.
// Assumes one-cycle request strobes on sys_clk_i, launched just after a rising edge.
`timescale 1ns/1ps
`include "tdcs_params.svh"
module tdcs_host_model (
  input  wire logic              sys_clk_i,
  output tdcs_pkg::tdcs_io_req_s io_req_o,
  input  wire logic [7:0]        io_rdata_i,
  input  wire logic              io_rdata_valid_i
);
  import tdcs_pkg::*;

  initial io_req_o = '0;

  task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge sys_clk_i);
    io_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk_i);
    io_req_o <= '0;
  endtask

  task automatic io_read(input logic [15:0] addr, output logic [7:0] data, output logic valid);
    @(posedge sys_clk_i);
    io_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge sys_clk_i);
    io_req_o <= '0;
    #1;
    data = io_rdata_i;
    valid = io_rdata_valid_i;
  endtask

  // The index always goes out first, so a data cycle never lands on a stale index.
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] data);
    io_write(`TDCS_IDX_PORT, idx);
    io_write(`TDCS_DATA_PORT, data);
  endtask

  task automatic reg_read(input logic [7:0] idx, output logic [7:0] data, output logic valid);
    io_write(`TDCS_IDX_PORT, idx);
    io_read(`TDCS_DATA_PORT, data, valid);
  endtask
endmodule // tdcs_host_model

// [bench/tb_test_debug_clock_select_regs.sv]
// Self-checking testbench for the test, debug and clock select register bank.
// Assumes tdcs_pkg, tdcs_params.svh and the host model are compiled before it.
`timescale 1ns/1ps
`include "tdcs_params.svh"
module tb_test_debug_clock_select_regs;
  import tdcs_pkg::*;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic vld; logic [3:0] pins; logic rdy;} tdcs_row_s;

  logic           sys_clk_i   = 1'b0;
  logic           sys_rst_i   = 1'b1;
  tdcs_io_req_s   io_req;
  logic [7:0]     rd;
  logic           vld;
  logic [7:0]     io_rdata;
  logic           io_rdata_valid;
  logic           misc_wr     = 1'b0;
  logic [7:0]     misc_wdata  = 8'h00;
  logic           ext_wr      = 1'b0;
  logic [7:0]     ext_wdata   = 8'h00;
  logic [3:0]     clk_sel_pins;
  logic           rom_wide;
  logic [15:0]    sd_o;
  logic           sd_oe;
  logic           text_mode   = 1'b1;
  logic [7:0]     font_o;
  logic [7:0]     attr_o;
  logic [7:0]     pix_o;
  logic           mem_wr_done = 1'b0;
  logic           vsync_in    = 1'b0;
  logic [7:0]     pix_hi_in   = 8'hD4;
  logic           cache_flush;
  logic           vsync_o;
  logic [7:0]     pixel_hi_o;
  logic           force_rdy;
  logic [15:0]    samp [8];
  logic           hit;
  logic           ok;
  int             bad_count   = 0;
  int             num_checks  = 0;
  int             cyc         = 0;
  tdcs_crt_cnt_s  crt         = '{vcnt: 11'h5A1, row_scan: 5'h0C, disp_addr: 23'h123456, hcnt: 16'h789A};
  tdcs_dbg_set_t  dbg_set     = 56'h77665544332211;
  tdcs_row_s      rows [6]    = '{'{8'h04, 8'h01, 8'h01, 1'b1, 4'h0, 1'b1}, '{8'h04, 8'h00, 8'h00, 1'b1, 4'h0, 1'b0},
                                  '{8'h06, 8'hA5, 8'hA5, 1'b1, 4'h5, 1'b0}, '{8'h06, 8'h3C, 8'h3C, 1'b1, 4'hC, 1'b0},
                                  '{8'h07, 8'hFF, 8'h5B, 1'b1, 4'hC, 1'b0}, '{8'h05, 8'h77, 8'h00, 1'b0, 4'hC, 1'b0}};

  always #2 sys_clk_i = ~sys_clk_i;

  tdcs_regs i_dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .io_req_i(io_req), .io_rdata_o(io_rdata),
    .io_rdata_valid_o(io_rdata_valid), .misc_out_wr_i(misc_wr), .misc_out_wdata_i(misc_wdata),
    .ext_d_wr_i(ext_wr), .ext_d_wdata_i(ext_wdata), .clk_sel_pins_o(clk_sel_pins),
    .mem_data_strap_lines_i(8'h5B), .rom_wide_o(rom_wide), .system_data_bus_i(16'h5AC3),
    .system_data_bus_o(sd_o), .system_data_bus_oe_o(sd_oe), .crt_cnt_i(crt), .text_mode_i(text_mode),
    .font_data_i(8'hE1), .attr_data_i(8'hE2), .graphics_pixel_data_i(8'hE3), .font_data_o(font_o),
    .attr_data_o(attr_o), .graphics_pixel_data_o(pix_o), .mem_wr_done_i(mem_wr_done),
    .cache_flush_o(cache_flush), .vsync_i(vsync_in), .vsync_o(vsync_o), .dbg_set_i(dbg_set),
    .pixel_hi_i(pix_hi_in), .pixel_hi_o(pixel_hi_o), .coproc_force_ready_o(force_rdy)
  );

  tdcs_host_model i_host (
    .sys_clk_i(sys_clk_i), .io_req_o(io_req), .io_rdata_i(io_rdata), .io_rdata_valid_i(io_rdata_valid)
  );

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic flush_pulse(input logic exp);
    @(posedge sys_clk_i);
    mem_wr_done <= 1'b1;
    @(posedge sys_clk_i);
    mem_wr_done <= 1'b0;
    #1;
    chk_bit("flush", exp, cache_flush);
  endtask

  function automatic logic [15:0] slice_exp(input logic [2:0] k);
    case (k)
      3'h1: slice_exp = {8'h00, crt.vcnt[10:8], crt.row_scan};
      3'h3: slice_exp = {8'h00, crt.disp_addr[7:0]};
      3'h4: slice_exp = {8'h00, crt.disp_addr[15:8]};
      3'h5: slice_exp = {9'h000, crt.disp_addr[22:16]};
      3'h6: slice_exp = {8'h00, crt.hcnt[7:0]};
      3'h7: slice_exp = {8'h00, crt.hcnt[15:8]};
      default: slice_exp = {5'h00, crt.vcnt};
    endcase
  endfunction

  // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    tick(1);
    chk_byte("pins", 8'h00, {4'h0, clk_sel_pins});
    tick(6);
    chk_bit("rom_wide", 1'b1, rom_wide);
    i_host.reg_read(`TDCS_IDX_TEST1, rd, vld);
    chk_byte("test1", 8'h00, rd);
    $display("test reset done");
    foreach (rows[i])
    begin
      i_host.reg_write(rows[i].idx, rows[i].wd);
      i_host.reg_read(rows[i].idx, rd, vld);
      chk_byte("rdata", rows[i].rd, rd);
      chk_bit("valid", rows[i].vld, vld);
      chk_byte("pins", {4'h0, rows[i].pins}, {4'h0, clk_sel_pins});
      chk_bit("ready", rows[i].rdy, force_rdy);
    end
    i_host.io_read(`TDCS_IDX_PORT, rd, vld);
    chk_byte("index", 8'h05, rd);
    $display("test table done");
    // A real host follows a clock change with a sequencer reset, which lives outside this bank.
    i_host.reg_write(`TDCS_IDX_CLKSEL, 8'h00);
    @(posedge sys_clk_i);
    misc_wdata <= 8'h08;
    misc_wr <= 1'b1;
    @(posedge sys_clk_i);
    misc_wr <= 1'b0;
    ext_wdata <= 8'h20;
    ext_wr <= 1'b1;
    @(posedge sys_clk_i);
    ext_wr <= 1'b0;
    tick(1);
    chk_byte("pins", 8'h06, {4'h0, clk_sel_pins});
    i_host.reg_read(`TDCS_IDX_CLKSEL, rd, vld);
    chk_byte("clksel", 8'h06, rd);
    $display("test shared select done");
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h20);
    tick(3);
    chk_bit("vsync", 1'b1, vsync_o);
    @(posedge sys_clk_i);
    vsync_in <= 1'b1;
    tick(1);
    chk_bit("vsync", 1'b0, vsync_o);
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h00);
    tick(3);
    chk_bit("vsync", 1'b1, vsync_o);
    $display("test vsync done");
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h80);
    tick(3);
    chk_bit("sd_oe", 1'b1, sd_oe);
    for (int i = 0; i < 8; i++)
    begin
      samp[i] = sd_o;
      tick(1);
    end
    hit = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      ok = 1'b1;
      for (int i = 0; i < 8; i++)
        if (samp[i] !== slice_exp(3'(k + i)))
          ok = 1'b0;
      hit = hit | ok;
    end
    chk_bit("slice_order", 1'b1, hit);
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h00);
    tick(3);
    chk_bit("sd_oe", 1'b0, sd_oe);
    $display("test counter done");
    i_host.reg_write(`TDCS_IDX_TEST1, 8'hA1);
    tick(8);
    chk_byte("font", 8'h5A, font_o);
    chk_byte("attr", 8'hC3, attr_o);
    @(posedge sys_clk_i);
    text_mode <= 1'b0;
    tick(3);
    chk_byte("pixel", 8'h5A, pix_o);
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h21);
    tick(3);
    chk_byte("pixel", 8'hE3, pix_o);
    $display("test scan done");
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h10);
    flush_pulse(1'b1);
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h00);
    flush_pulse(1'b0);
    $display("test flush done");
    for (int s = 0; s < 8; s++)
    begin
      i_host.reg_write(`TDCS_IDX_TEST1, 8'h40 | 8'(s));
      tick(3);
      chk_byte("debug", (s == 7) ? 8'h00 : 8'(dbg_set[s]), pixel_hi_o);
    end
    @(posedge sys_clk_i);
    pix_hi_in <= 8'h3B;
    i_host.reg_write(`TDCS_IDX_TEST1, 8'h00);
    tick(3);
    chk_byte("debug", 8'h3B, pixel_hi_o);
    $display("test debug done");
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    tick(2);
    chk_byte("pins", 8'h00, {4'h0, clk_sel_pins});
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    tick(1);
    chk_bit("rom_wide", 1'b0, rom_wide);
    tick(6);
    chk_bit("rom_wide", 1'b1, rom_wide);
    $display("test mid reset done");
    wrap_up();
  end
endmodule // tb_test_debug_clock_select_regs
